// file: rtl/frpd_consts.vh
/*
  Constants for the resume, power-down and identification command block:
  opcodes, phase lengths, bus widths, state codes and timing figures.
  Assumes the includer runs on a 5 ns system clock; holds definitions only.
*/
// What this block does
// (R1) Resume 7Ah is taken only while suspended and not busy.
// (R2) Taken resume clears suspend at once; busy must rise within 200 ns.
// (R3) Resume with suspend clear or busy set changes nothing.
// (R4) Resume after a power loss during suspend is ignored.
// (R5) Host waits the suspend guard time after a resume before suspending.
// (R6) Power-down B9h runs only if chip select rises right after bit eight.
// (R7) Power-down follows within entry time; then only ABh is recognised.
// (R8) The block always leaves reset in normal operation.
// (R9) Plain ABh release: other commands wait out the wake time.
// (R10) ABh plus three dummy bytes repeats the device ID, MSB first.
// (R11) ABh release with ID read waits out the longer wake time.
// (R12) ABh is ignored while busy, leaving the running cycle alone.
// (R13) 90h with address 000000h returns manufacturer then device ID.
// (R14) Address 000001h swaps the order; the IDs alternate until deselect.
// (R15) 92h takes address and mode two bits per clock; IDs return likewise.
// (R16) Host drives the continuous read mode bits as Fxh.
// (R17) 94h takes address, mode, four dummy clocks; IDs return four-wide.
// (R18) 4Bh takes four dummy bytes then returns the 64-bit unique number.
// (R19) A taken suspend sets the suspend flag at once.
// (R20) Power loss while suspended clears the suspend flag.
// (R21) Command, address and mode bits are sampled on rising clock, MSB first.
// (R22) Chip select rising ends any ID read and floats the outputs.
`ifndef FRPD_CONSTS_VH
`define FRPD_CONSTS_VH

// Opcodes
`define FRPD_OP_RESUME     8'h7a
`define FRPD_OP_PWR_DOWN   8'hb9
`define FRPD_OP_RELEASE    8'hab
`define FRPD_OP_ID_SINGLE  8'h90
`define FRPD_OP_ID_DUAL    8'h92
`define FRPD_OP_ID_QUAD    8'h94
`define FRPD_OP_UNIQUE     8'h4b

// Link clocks before the first output bit, and address clocks
`define FRPD_CMD_LAST_BIT  6'd7
`define FRPD_PRE_SINGLE    6'd24
`define FRPD_PRE_DUAL      6'd16
`define FRPD_PRE_QUAD      6'd12
`define FRPD_PRE_RELEASE   6'd24
`define FRPD_PRE_UNIQUE    6'd32
`define FRPD_ADDR_SINGLE   6'd24
`define FRPD_ADDR_DUAL     6'd12
`define FRPD_ADDR_QUAD     6'd6

// Lane widths
`define FRPD_W1            3'd1
`define FRPD_W2            3'd2
`define FRPD_W4            3'd4

// Frame states
`define FRPD_ST_CMD        2'd0
`define FRPD_ST_PRE        2'd1
`define FRPD_ST_OUT        2'd2
`define FRPD_ST_SKIP       2'd3

// Power states
`define FRPD_PS_NORMAL     2'd0
`define FRPD_PS_ENTERING   2'd1
`define FRPD_PS_DOWN       2'd2
`define FRPD_PS_WAKING     2'd3

// Timing, in ns, and derived cycle counts at 200 MHz
`define FRPD_CLK_NS        5
`define FRPD_ENTRY_NS      3000
`define FRPD_WAKE_NS       3000
`define FRPD_WAKE_ID_NS    3500
`define FRPD_RESUME_NS     200
`define FRPD_ENTRY_CYC     (`FRPD_ENTRY_NS / `FRPD_CLK_NS)
`define FRPD_WAKE_CYC      ((`FRPD_WAKE_NS + `FRPD_CLK_NS - 1) / `FRPD_CLK_NS)
`define FRPD_WAKE_ID_CYC   ((`FRPD_WAKE_ID_NS + `FRPD_CLK_NS - 1) / `FRPD_CLK_NS)
`define FRPD_RESUME_CYC    (`FRPD_RESUME_NS / `FRPD_CLK_NS)
`define FRPD_TMR_W         10

`endif

// file: rtl/frpd_sync.v
/*
  Three-stage pin synchroniser. The filtered level only moves once the
  second and third stages agree. Assumes asynchronous inputs and i_rst
  synchronous to i_sys_clk.
*/
`timescale 1ns/100ps
module frpd_sync #(
  parameter       W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input  wire         i_sys_clk,
  input  wire         i_rst,
  // Pins in, filtered level out
  input  wire [W-1:0] i_pin,
  output reg  [W-1:0] o_level
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      // Only s2 reads s1; the agreement check rides on s2 and s3
      always @(posedge i_sys_clk) begin
        if (i_rst) begin
          s1_reg[g]  <= INIT[g];
          s2_reg[g]  <= INIT[g];
          s3_reg[g]  <= INIT[g];
          o_level[g] <= INIT[g];
        end else begin
          s1_reg[g] <= i_pin[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            o_level[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate

endmodule

// file: rtl/frpd_timer.v
/*
  Down-counting one-shot timer. A load restarts it; o_done pulses one cycle
  when the count runs out. Assumes counts of at least one.
*/
`timescale 1ns/100ps
`include "frpd_consts.vh"
module frpd_timer (
  // Clock and reset
  input  wire                   i_sys_clk,
  input  wire                   i_rst,
  // Control
  input  wire                   i_load,
  input  wire [`FRPD_TMR_W-1:0] i_count,
  // Status
  output reg                    o_running,
  output reg                    o_done
);

  reg [`FRPD_TMR_W-1:0] cnt_reg;

  // A reload while running simply restarts the wait
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_reg   <= {`FRPD_TMR_W{1'b0}};
      o_running <= 1'b0;
      o_done    <= 1'b0;
    end else if (i_load) begin
      cnt_reg   <= i_count;
      o_running <= 1'b1;
      o_done    <= 1'b0;
    end else if (o_running) begin
      cnt_reg   <= cnt_reg - {{(`FRPD_TMR_W-1){1'b0}}, 1'b1};
      o_done    <= (cnt_reg == {{(`FRPD_TMR_W-1){1'b0}}, 1'b1});
      o_running <= (cnt_reg != {{(`FRPD_TMR_W-1){1'b0}}, 1'b1});
    end else begin
      o_done <= 1'b0;
    end
  end

endmodule

// file: rtl/frpd_cmd.v
/*
  Serial-flash command block for resume, deep power-down, release and the
  identification reads. Samples chip select, link clock and the four data
  pins through synchronisers and finds link clock edges itself.
  Assumes the link clock runs well below a quarter of i_sys_clk, and that the
  erase/program sequencer owns busy and raises it after o_resume_go.
*/
`timescale 1ns/100ps
`include "frpd_consts.vh"
module frpd_cmd #(
  parameter [7:0]  MFR_ID    = 8'h5a,                 // Arbitrary value
  parameter [7:0]  DEV_ID    = 8'h3c,                 // Arbitrary value
  parameter [63:0] UNIQUE_ID = 64'h0123456789abcdef   // Arbitrary value
) (
  // Clock and reset
  input  wire       i_sys_clk,
  input  wire       i_rst,
  // Serial link pins; io0 is serial_in_pin, io1 the single-wide output
  input  wire       i_cs_n,
  input  wire       i_sclk,
  input  wire [3:0] i_io,
  output reg  [3:0] o_io,
  output reg  [3:0] o_io_oe,
  // Erase/program sequencer
  input  wire       i_busy,
  input  wire       i_suspend_set,
  input  wire       i_power_lost,
  output reg        o_suspend_flag,
  output reg        o_resume_go,
  // Power state
  output reg        o_powered_down,
  output reg        o_cmds_enabled
);

  // Lane width of each read command
  function [2:0] cmd_width;
    input [7:0] op;
    begin
      case (op)
        `FRPD_OP_ID_DUAL: cmd_width = `FRPD_W2;
        `FRPD_OP_ID_QUAD: cmd_width = `FRPD_W4;
        default:          cmd_width = `FRPD_W1;
      endcase
    end
  endfunction

  // Input clocks before output starts
  function [5:0] cmd_pre;
    input [7:0] op;
    begin
      case (op)
        `FRPD_OP_ID_DUAL: cmd_pre = `FRPD_PRE_DUAL;
        `FRPD_OP_ID_QUAD: cmd_pre = `FRPD_PRE_QUAD;
        `FRPD_OP_UNIQUE:  cmd_pre = `FRPD_PRE_UNIQUE;
        `FRPD_OP_RELEASE: cmd_pre = `FRPD_PRE_RELEASE;
        default:          cmd_pre = `FRPD_PRE_SINGLE;
      endcase
    end
  endfunction

  // Clock that carries the address LSB
  function [5:0] cmd_addr;
    input [7:0] op;
    begin
      case (op)
        `FRPD_OP_ID_DUAL: cmd_addr = `FRPD_ADDR_DUAL;
        `FRPD_OP_ID_QUAD: cmd_addr = `FRPD_ADDR_QUAD;
        default:          cmd_addr = `FRPD_ADDR_SINGLE;
      endcase
    end
  endfunction

  // Synchronised pins
  wire       cs_n_f;
  wire       sclk_f;
  wire [3:0] io_f;

  frpd_sync #(.W(2), .INIT(2'b01)) u_sync_ctl (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     ({i_sclk, i_cs_n}),
    .o_level   ({sclk_f, cs_n_f})
  );

  frpd_sync #(.W(4), .INIT(4'h0)) u_sync_io (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_io),
    .o_level   (io_f)
  );

  // Edge detection on the filtered levels
  reg  sclk_prev_reg;
  reg  cs_prev_reg;
  wire sclk_rise = sclk_f & ~sclk_prev_reg & ~cs_n_f;
  wire sclk_fall = ~sclk_f & sclk_prev_reg & ~cs_n_f;
  wire cs_rise   = cs_n_f & ~cs_prev_reg;

  // Frame and power state
  reg  [1:0]  st_reg;
  reg  [5:0]  cnt_reg;
  reg  [7:0]  cmd_reg;
  reg  [7:0]  op_reg;
  reg  [2:0]  width_reg;
  reg         swap_reg;
  reg         extra_reg;
  reg         pd_req_reg;
  reg         rel_req_reg;
  reg  [63:0] data_reg;
  reg  [1:0]  pw_reg;
  reg  [1:0]  pw_next;

  wire [7:0]  op_next   = {cmd_reg[6:0], io_f[0]};
  wire [5:0]  cnt_inc   = cnt_reg + 6'd1;
  wire        pw_asleep = (pw_reg == `FRPD_PS_DOWN) || (pw_reg == `FRPD_PS_ENTERING);
  wire        resume_ok = o_suspend_flag & ~i_busy;
  wire        tmr_done;
  wire        tmr_load  = cs_rise & ((pd_req_reg & ~extra_reg) | rel_req_reg);
  wire [`FRPD_TMR_W-1:0] tmr_count;

  // Cycle counts are integer expressions; cut to the timer width on purpose
  wire [31:0] entry_cyc_w   = `FRPD_ENTRY_CYC;
  wire [31:0] wake_cyc_w    = `FRPD_WAKE_CYC;
  wire [31:0] wake_id_cyc_w = `FRPD_WAKE_ID_CYC;

  // Release wait depends on whether any link clock followed the opcode
  assign tmr_count = rel_req_reg ?
                     (extra_reg ? wake_id_cyc_w[`FRPD_TMR_W-1:0] :
                                  wake_cyc_w[`FRPD_TMR_W-1:0]) :
                     entry_cyc_w[`FRPD_TMR_W-1:0];

  frpd_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_running (),
    .o_done    (tmr_done)
  );

  // Edge history
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_f;
      cs_prev_reg   <= cs_n_f;
    end
  end

  // Power state transitions; reset lands in normal operation [R8]
  always @* begin
    pw_next = pw_reg;
    case (pw_reg)
      `FRPD_PS_NORMAL: begin
        if (tmr_load && !rel_req_reg) begin
          pw_next = `FRPD_PS_ENTERING;              // [R6] [R7]
        end
      end
      `FRPD_PS_ENTERING: begin
        if (tmr_load && rel_req_reg) begin
          pw_next = `FRPD_PS_WAKING;
        end else if (tmr_done) begin
          pw_next = `FRPD_PS_DOWN;                  // [R7]
        end
      end
      `FRPD_PS_DOWN: begin
        if (tmr_load && rel_req_reg) begin
          pw_next = `FRPD_PS_WAKING;                // [R9] [R11]
        end
      end
      `FRPD_PS_WAKING: begin
        if (tmr_done) begin
          pw_next = `FRPD_PS_NORMAL;                // [R9] [R11]
        end
      end
      default: pw_next = `FRPD_PS_NORMAL;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      pw_reg         <= `FRPD_PS_NORMAL;            // [R8]
      o_powered_down <= 1'b0;
      o_cmds_enabled <= 1'b1;
    end else begin
      pw_reg         <= pw_next;
      o_powered_down <= (pw_next != `FRPD_PS_NORMAL) && (pw_next != `FRPD_PS_WAKING);
      o_cmds_enabled <= (pw_next == `FRPD_PS_NORMAL);
    end
  end

  // Suspend flag: power loss wins, then a suspend set, then a resume clear
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_suspend_flag <= 1'b0;
      o_resume_go    <= 1'b0;
    end else begin
      o_resume_go <= 1'b0;
      if (i_power_lost) begin
        o_suspend_flag <= 1'b0;                     // [R20] [R4]
      end else if (i_suspend_set) begin
        o_suspend_flag <= 1'b1;                     // [R19]
      end else if (sclk_rise && st_reg == `FRPD_ST_CMD && cnt_reg == `FRPD_CMD_LAST_BIT &&
                   op_next == `FRPD_OP_RESUME && pw_reg == `FRPD_PS_NORMAL && resume_ok) begin
        o_suspend_flag <= 1'b0;                     // [R1] [R2]
        o_resume_go    <= 1'b1;                     // [R2]
      end
    end
  end

  // Frame engine: sample on rising link clock, drive on falling
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg      <= `FRPD_ST_CMD;
      cnt_reg     <= 6'd0;
      cmd_reg     <= 8'h00;
      op_reg      <= 8'h00;
      width_reg   <= `FRPD_W1;
      swap_reg    <= 1'b0;
      extra_reg   <= 1'b0;
      pd_req_reg  <= 1'b0;
      rel_req_reg <= 1'b0;
      data_reg    <= 64'h0;
      o_io        <= 4'h0;
      o_io_oe     <= 4'h0;
    end else if (cs_n_f) begin
      // Deselect ends every read and floats the pins [R22]
      st_reg      <= `FRPD_ST_CMD;
      cnt_reg     <= 6'd0;
      extra_reg   <= 1'b0;
      swap_reg    <= 1'b0;                          // No stale order into the next read [R14]
      pd_req_reg  <= 1'b0;
      rel_req_reg <= 1'b0;
      o_io_oe     <= 4'h0;                          // [R22]
      o_io        <= 4'h0;
    end else if (sclk_rise) begin
      case (st_reg)
        `FRPD_ST_CMD: begin
          cmd_reg <= op_next;                       // [R21]
          cnt_reg <= cnt_inc;
          if (cnt_reg == `FRPD_CMD_LAST_BIT) begin
            cnt_reg   <= 6'd0;
            op_reg    <= op_next;
            width_reg <= cmd_width(op_next);
            st_reg    <= `FRPD_ST_SKIP;
            if (pw_reg == `FRPD_PS_WAKING) begin
              st_reg <= `FRPD_ST_SKIP;              // [R9] [R11]
            end else if (op_next == `FRPD_OP_RELEASE) begin
              if (!i_busy) begin                    // [R12]
                rel_req_reg <= pw_asleep;
                st_reg      <= `FRPD_ST_PRE;        // [R10]
              end
            end else if (pw_asleep) begin
              st_reg <= `FRPD_ST_SKIP;              // [R7]
            end else begin
              case (op_next)
                `FRPD_OP_PWR_DOWN:  pd_req_reg <= 1'b1;           // [R6]
                `FRPD_OP_ID_SINGLE: st_reg     <= `FRPD_ST_PRE;   // [R13]
                `FRPD_OP_ID_DUAL:   st_reg     <= `FRPD_ST_PRE;   // [R15]
                `FRPD_OP_ID_QUAD:   st_reg     <= `FRPD_ST_PRE;   // [R17]
                `FRPD_OP_UNIQUE:    st_reg     <= `FRPD_ST_PRE;   // [R18]
                default:            st_reg     <= `FRPD_ST_SKIP;  // [R3]
              endcase
            end
          end
        end
        `FRPD_ST_PRE: begin
          extra_reg <= 1'b1;                        // [R6] [R11]
          cnt_reg   <= cnt_inc;
          if (cnt_inc == cmd_addr(op_reg)) begin
            swap_reg <= io_f[0];                    // [R14] [R21]
          end
          if (cnt_inc == cmd_pre(op_reg)) begin
            st_reg <= `FRPD_ST_OUT;
            if (op_reg == `FRPD_OP_RELEASE) begin
              data_reg <= {8{DEV_ID}};              // [R10]
            end else if (op_reg == `FRPD_OP_UNIQUE) begin
              data_reg <= UNIQUE_ID;                // [R18]
            end else if (swap_reg || (cnt_inc == cmd_addr(op_reg) && io_f[0])) begin
              data_reg <= {4{DEV_ID, MFR_ID}};      // [R14]
            end else begin
              data_reg <= {4{MFR_ID, DEV_ID}};      // [R13]
            end
          end
        end
        default: begin
          extra_reg <= 1'b1;                        // [R6]
        end
      endcase
    end else if (sclk_fall && st_reg == `FRPD_ST_OUT) begin
      // Rotating a 64-bit word repeats and alternates the IDs [R14]
      case (width_reg)
        `FRPD_W4: begin
          o_io     <= data_reg[63:60];              // [R17]
          o_io_oe  <= 4'hf;
          data_reg <= {data_reg[59:0], data_reg[63:60]};
        end
        `FRPD_W2: begin
          o_io     <= {2'b00, data_reg[63:62]};     // [R15]
          o_io_oe  <= 4'h3;
          data_reg <= {data_reg[61:0], data_reg[63:62]};
        end
        default: begin
          o_io     <= {2'b00, data_reg[63], 1'b0};  // [R10] [R13] [R18]
          o_io_oe  <= 4'h2;
          data_reg <= {data_reg[62:0], data_reg[63]};
        end
      endcase
    end
  end

endmodule

// file: tb/frpd_host.sv
/*
  Host serial controller model: drives chip select, link clock and data
  lanes, and samples the device lanes. Assumes mode 0 and an 80 ns clock.
*/
`timescale 1ns/100ps
module frpd_host (
  // Link pins toward the device
  output logic       o_cs_n,
  output logic       o_sclk,
  output logic [3:0] o_io,
  // Device output lanes
  input  wire  [3:0] i_dq
);
  localparam int HALF = 40;
  // Deselected with the clock low at time zero
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io   = 4'h0;
  end
  // Select; the clock stays low until the first bit is set up
  task automatic sel();
    o_cs_n = 1'b0;
    #(HALF);
  endtask
  // Shift n clocks of w lanes, MSB first, set while the clock is low
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int k = n - 1; k >= 0; k--) begin
      if (w == 1) o_io[0] = v[k];
      else if (w == 2) o_io[1:0] = v[2*k+1 -: 2];
      else o_io = v[4*k+3 -: 4];
      #(HALF) o_sclk = 1'b1;
      #(HALF) o_sclk = 1'b0;
    end
    o_io = ~o_io;  // Released lanes must not keep their last value
  endtask
  // Gather the lanes just before each rise; released lanes keep toggling
  task automatic recv(output logic [63:0] d, input int n, input int w);
    d = 64'h0;
    for (int k = 0; k < n; k++) begin
      #(HALF - 2);
      if (w == 1) d = {d[62:0], i_dq[1]};
      else if (w == 2) d = {d[61:0], i_dq[1:0]};
      else d = {d[59:0], i_dq};
      #2 o_sclk = 1'b1;
      #(HALF) o_sclk = 1'b0;
      o_io = ~o_io;
    end
  endtask
  // Chip select rises with no further clock rise
  task automatic desel();
    #(HALF) o_cs_n = 1'b1;
  endtask
endmodule

// file: tb/frpd_cmd_assertions.sv
/*
  Checker for the resume, power-down and ID command block.
  Sees only the block's top ports; bound to every frpd_cmd instance.
*/
`timescale 1ns/100ps
module frpd_cmd_chk (
  // Clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  // Link and sequencer inputs
  input wire logic       i_cs_n,
  input wire logic       i_busy,
  input wire logic       i_suspend_set,
  input wire logic       i_power_lost,
  // Block outputs
  input wire logic [3:0] o_io_oe,
  input wire logic       o_suspend_flag,
  input wire logic       o_resume_go,
  input wire logic       o_powered_down,
  input wire logic       o_cmds_enabled
);
  localparam int WAKE_MIN = 595;
  logic [9:0] wake_cnt_reg;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Waking cycles; saturates so a stuck wake cannot wrap back to a legal value
  always @(posedge i_sys_clk) begin
    if (i_rst || o_cmds_enabled || o_powered_down) begin
      wake_cnt_reg <= 10'h0;
    end else if (wake_cnt_reg != 10'h3ff) begin
      wake_cnt_reg <= wake_cnt_reg + 10'h1;
    end
  end
  property p_go_one; o_resume_go |=> !o_resume_go; endproperty
  a_go_one: assert property (p_go_one) else $error("Resume pulse too long");
  property p_go_clr; o_resume_go |-> !o_suspend_flag && $past(o_suspend_flag); endproperty
  a_go_clr: assert property (p_go_clr) else $error("Resume without flag clear");
  property p_go_idle; o_resume_go |-> !$past(i_busy); endproperty
  a_go_idle: assert property (p_go_idle) else $error("Resume taken while busy");
  property p_set; i_suspend_set && !i_power_lost |=> o_suspend_flag; endproperty
  a_set: assert property (p_set) else $error("Suspend flag not set");
  property p_lost; i_power_lost |=> !o_suspend_flag; endproperty
  a_lost: assert property (p_lost) else $error("Power loss kept flag");
  property p_fall; $fell(o_suspend_flag) |-> o_resume_go || $past(i_power_lost); endproperty
  a_fall: assert property (p_fall) else $error("Flag dropped without cause");
  property p_rst; $fell(i_rst) |-> o_cmds_enabled && !o_powered_down && o_io_oe == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("Reset state not normal");
  property p_oe; o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
  a_oe: assert property (p_oe) else $error("Illegal lane enable");
  property p_float; i_cs_n [*8] |-> o_io_oe == 4'h0; endproperty
  a_float: assert property (p_float) else $error("Lanes driven while deselected");
  property p_pd; o_powered_down |-> !o_cmds_enabled; endproperty
  a_pd: assert property (p_pd) else $error("Commands on in power-down");
  property p_wake; $rose(o_cmds_enabled) |-> wake_cnt_reg >= WAKE_MIN; endproperty
  a_wake: assert property (p_wake) else $error("Wake shorter than release time");
endmodule

bind frpd_cmd frpd_cmd_chk u_frpd_cmd_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_busy(i_busy),
  .i_suspend_set(i_suspend_set), .i_power_lost(i_power_lost), .o_io_oe(o_io_oe),
  .o_suspend_flag(o_suspend_flag), .o_resume_go(o_resume_go),
  .o_powered_down(o_powered_down), .o_cmds_enabled(o_cmds_enabled)
);

// file: tb/frpd_cmd_tb.sv
/*
  Self-checking bench for the resume, power-down and ID command block.
  Assumes the host model drives the link; the bench plays the sequencer.
*/
`timescale 1ns/100ps
module frpd_cmd_tb;
  localparam logic [7:0]  MFR = 8'ha5;                 // Arbitrary value
  localparam logic [7:0]  DEV = 8'h17;                 // Arbitrary value
  localparam logic [63:0] UID = 64'hfedcba9876543210;  // Arbitrary value
  logic        sys_clk;
  logic        rst;
  logic        busy;
  logic        sset;
  logic        plost;
  wire         cs_n;
  wire         sclk;
  wire  [3:0]  io_in;
  wire  [3:0]  io_out;
  wire  [3:0]  oe;
  wire         flag;
  wire         go;
  wire         pd;
  wire         en;
  // Undriven lanes read back inverted, so a late or missing enable shows up
  wire  [3:0]  dq = (io_out & oe) | (~io_out & ~oe);
  int          err_count = 0;
  int          compares = 0;
  int          go_cnt = 0;
  logic [63:0] d;

  frpd_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID)) u_frpd_cmd (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_io(io_in), .o_io(io_out), .o_io_oe(oe), .i_busy(busy),
    .i_suspend_set(sset), .i_power_lost(plost), .o_suspend_flag(flag),
    .o_resume_go(go), .o_powered_down(pd), .o_cmds_enabled(en));
  frpd_host u_frpd_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_io(io_in), .i_dq(dq));

  // System clock, 5 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Count accepted resumes
  always @(posedge sys_clk) begin
    if (go === 1'b1) go_cnt++;
  end

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Opcode, single-wide filler clocks, then n bits read back
  task automatic frame(input logic [7:0] op, input int pre, input int n);
    u_frpd_host.sel();
    u_frpd_host.send(op, 8, 1);
    u_frpd_host.send(0, pre, 1);
    u_frpd_host.recv(d, n, 1);
  endtask
  task automatic close();
    u_frpd_host.desel();
    cyc(8);
  endtask
  task automatic cmd(input logic [7:0] op);
    frame(op, 0, 0);
    close();
  endtask
  // Bounded wait for normal operation after a release
  task automatic wait_en(input int lim);
    int k = 0;
    while (en !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
    chk("wake_done", {en, pd}, 2'b10);
    if (en !== 1'b1) report_and_stop();  // Timed out; the miss is counted above
  endtask

  task automatic t_reset();
    chk("rst_state", {en, pd, flag, oe}, 7'h40);
  endtask
  // All three ID reads with both start addresses
  task automatic t_ids();
    logic [7:0] ops [3] = '{8'h90, 8'h92, 8'h94};
    logic [3:0] oes [3] = '{4'h2, 4'h3, 4'hf};
    int         ws [3]  = '{1, 2, 4};
    logic [15:0] p;
    for (int i = 2; i >= 0; i--) begin  // Single last, after a swapped read
      for (int a = 0; a < 2; a++) begin
        p = a ? {DEV, MFR} : {MFR, DEV};
        u_frpd_host.sel();
        u_frpd_host.send(ops[i], 8, 1);
        if (i == 0) u_frpd_host.send(a, 24, 1);
        else u_frpd_host.send({23'h0, a[0], 8'hf0}, 32 / ws[i], ws[i]);
        if (i == 2) u_frpd_host.send(0, 4, 4);
        u_frpd_host.recv(d, 32 / ws[i], ws[i]);
        chk("id_pair", d, {32'h0, p, p});
        chk("id_lanes", oe, oes[i]);
        close();
        chk("id_float", oe, 4'h0);
      end
    end
  endtask
  task automatic t_idents();
    frame(8'hab, 24, 16);
    chk("dev_id", d, {48'h0, DEV, DEV});
    close();
    frame(8'h4b, 32, 64);
    chk("unique_id", d, UID);
    close();
  endtask
  task automatic t_resume();
    sset = 1'b1;
    cyc(1);
    sset = 1'b0;
    cyc(2);
    chk("flag_set", flag, 1'b1);
    busy = 1'b1;
    cmd(8'h7a);
    chk("res_busy", {go_cnt[3:0], flag}, 5'h01);
    busy = 1'b0;
    cmd(8'h7a);
    chk("res_ok", {go_cnt[3:0], flag}, 5'h02);
    cmd(8'h7a);
    chk("res_clear", {go_cnt[3:0], flag}, 5'h02);
    cyc(40);  // Guard time after the resume before suspending again
    sset = 1'b1;
    cyc(1);
    sset = 1'b0;
    plost = 1'b1;
    cyc(1);
    plost = 1'b0;
    cyc(2);
    chk("flag_lost", flag, 1'b0);
    cmd(8'h7a);
    chk("res_lost", go_cnt, 1);
  endtask
  task automatic t_pd();
    frame(8'hb9, 1, 0);
    close();
    chk("pd_stray", {pd, en}, 2'b01);
    cmd(8'hb9);
    chk("pd_enter", {pd, en}, 2'b10);
    frame(8'h90, 24, 8);
    chk("pd_quiet", oe, 4'h0);
    close();
    cmd(8'hab);
    cyc(570);  // Chip select held high for most of the release time
    chk("wake_early", en, 1'b0);
    wait_en(60);
    cmd(8'hb9);
    frame(8'hab, 24, 8);
    close();
    cyc(670);  // Longer hold when the release also read the ID
    chk("wake_id_early", en, 1'b0);
    wait_en(60);
    busy = 1'b1;
    frame(8'hab, 24, 8);
    chk("rel_busy", oe, 4'h0);
    close();
    busy = 1'b0;
    chk("rel_busy_en", {pd, en}, 2'b01);
  endtask

  initial begin
    rst = 1'b1;
    busy = 1'b0;
    sset = 1'b0;
    plost = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    cyc(4);
    t_reset();
    t_ids();
    t_idents();
    t_resume();
    t_pd();
    report_and_stop();
  end
endmodule
